// >>> rtl/measurement_calibration.sv
// Calibration datapath: thermistor, stack current, stack voltage, charge state
`timescale 1ns/100ps
module measurement_calibration #(
    parameter int ACC_W = 64
) (
    // Clock and reset
    input  wire logic                            aclk,
    input  wire logic                            aresetn,
    // AXI4-Lite write address
    input  wire logic [calib_pkg::AXI_AW-1:0]    awaddr,
    input  wire logic [2:0]                      awprot,
    input  wire logic                            awvalid,
    output wire logic                            awready,
    // AXI4-Lite write data
    input  wire logic [31:0]                     wdata,
    input  wire logic [3:0]                      wstrb,
    input  wire logic                            wvalid,
    output wire logic                            wready,
    // AXI4-Lite write response
    output wire logic [1:0]                      bresp,
    output wire logic                            bvalid,
    input  wire logic                            bready,
    // AXI4-Lite read address
    input  wire logic [calib_pkg::AXI_AW-1:0]    araddr,
    input  wire logic [2:0]                      arprot,
    input  wire logic                            arvalid,
    output wire logic                            arready,
    // AXI4-Lite read data
    output wire logic [31:0]                     rdata,
    output wire logic [1:0]                      rresp,
    output wire logic                            rvalid,
    input  wire logic                            rready,
    // Thermistor samples, Q16.16 volts
    input  wire logic                            therm_valid,
    output wire logic                            therm_ready,
    input  wire logic [31:0]                     therm_sample,
    // Current converter samples
    input  wire logic                            cur_valid,
    output wire logic                            cur_ready,
    input  wire logic [31:0]                     cur_sample,
    // Voltage converter samples
    input  wire logic                            volt_valid,
    output wire logic                            volt_ready,
    input  wire logic [31:0]                     volt_sample,
    // Calibrated results
    output wire logic                            temp_valid,
    output wire logic [31:0]                     temp_out,
    output wire logic                            current_valid,
    output wire logic [31:0]                     current_out,
    output wire logic                            voltage_valid,
    output wire logic [31:0]                     voltage_out,
    // Charge state and accumulated charge
    output wire calib_pkg::charge_state_t        charge_state,
    output wire logic [ACC_W-1:0]                charge_acc
);
    generate
        if (ACC_W < 32 || ACC_W > 64) begin : g_bad_acc
            $error("ACC_W must lie between 32 and 64");
        end
    endgenerate

    poly_if  pif ();
    scale_if cif ();
    scale_if vif ();

    logic [31:0]              cfg_ff [calib_pkg::NUM_CFG];
    logic                     lock_ff;
    logic                     aw_held_ff;
    logic                     w_held_ff;
    logic [calib_pkg::IDX_W-1:0] wr_idx_ff;
    logic [31:0]              wdata_ff;
    logic [3:0]               wstrb_ff;
    logic                     bvalid_ff;
    logic [1:0]               bresp_ff;
    logic                     rvalid_ff;
    logic [1:0]               rresp_ff;
    logic [31:0]              rdata_ff;
    calib_pkg::charge_state_t cstate_ff;
    calib_pkg::charge_state_t nxt_cstate;
    logic [ACC_W-1:0]         acc_ff;
    logic [ACC_W-1:0]         nxt_acc;

    // Write decode
    wire                          wr_fire   = aw_held_ff && w_held_ff && !bvalid_ff;
    wire                          wr_cfg    = wr_idx_ff < 6'(calib_pkg::NUM_CFG);
    wire                          wr_locked = lock_ff && calib_pkg::FACTORY_MASK[wr_idx_ff[3:0]];
    wire                          wr_is_lock = (wr_idx_ff == calib_pkg::IDX_LOCK);
    wire                          wr_ok     = (wr_cfg && !wr_locked) || wr_is_lock;
    wire                          lock_set  = wr_fire && wr_is_lock && wstrb_ff[0] && wdata_ff[0];

    // Read decode
    wire [calib_pkg::IDX_W-1:0]   ar_idx    = araddr[calib_pkg::AXI_AW-1:2];
    wire                          ar_fire   = arvalid && !rvalid_ff;
    wire                          rd_ok     = ar_idx <= calib_pkg::IDX_ACC_HI;
    wire [63:0]                   acc_ext   = 64'($signed(acc_ff));
    wire [31:0]                   rd_word   =
        (ar_idx < 6'(calib_pkg::NUM_CFG))   ? cfg_ff[ar_idx[3:0]] :
        (ar_idx == calib_pkg::IDX_LOCK)     ? {31'h0, lock_ff} :
        (ar_idx == calib_pkg::IDX_TEMP)     ? pif.result :
        (ar_idx == calib_pkg::IDX_CUR)      ? cif.result :
        (ar_idx == calib_pkg::IDX_VOLT)     ? vif.result :
        (ar_idx == calib_pkg::IDX_STATE)    ? {29'h0, cstate_ff} :
        (ar_idx == calib_pkg::IDX_ACC_LO)   ? acc_ext[31:0] :
        (ar_idx == calib_pkg::IDX_ACC_HI)   ? acc_ext[63:32] : 32'h0;

    assign awready = !aw_held_ff && !bvalid_ff;
    assign wready  = !w_held_ff && !bvalid_ff;
    assign bvalid  = bvalid_ff;
    assign bresp   = bresp_ff;
    assign arready = !rvalid_ff;
    assign rvalid  = rvalid_ff;
    assign rresp   = rresp_ff;
    assign rdata   = rdata_ff;

    // Write channel: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= calib_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_held_ff <= 1'b1;
            end else if (wr_fire) begin
                aw_held_ff <= 1'b0;
            end
            if (wvalid && wready) begin
                w_held_ff <= 1'b1;
            end else if (wr_fire) begin
                w_held_ff <= 1'b0;
            end
            if (wr_fire) begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= wr_ok ? calib_pkg::RESP_OKAY : calib_pkg::RESP_SLVERR;
            end else if (bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_idx_ff <= 6'h0;
            wdata_ff  <= 32'h0;
            wstrb_ff  <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                wr_idx_ff <= awaddr[calib_pkg::AXI_AW-1:2];
            end
            if (wvalid && wready) begin
                wdata_ff <= wdata;
                wstrb_ff <= wstrb;
            end
        end
    end

    // Read channel: answer one cycle after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rresp_ff  <= calib_pkg::RESP_OKAY;
            rdata_ff  <= 32'h0;
        end else if (ar_fire) begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= rd_ok ? calib_pkg::RESP_OKAY : calib_pkg::RESP_SLVERR;
            rdata_ff  <= rd_ok ? rd_word : 32'h0;
        end else if (rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // Lockdown is sticky until reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lock_ff <= 1'b0;
        end else if (lock_set) begin
            lock_ff <= 1'b1;
        end
    end

    // Configuration words with byte strobes
    genvar gi;
    generate
        for (gi = 0; gi < calib_pkg::NUM_CFG; gi++) begin : g_cfg
            wire hit = wr_fire && wr_ok && (wr_idx_ff == 6'(gi));
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    cfg_ff[gi] <= calib_pkg::CFG_RST[gi];
                end else if (hit) begin
                    for (int b = 0; b < 4; b++) begin
                        if (wstrb_ff[b]) begin
                            cfg_ff[gi][8*b +: 8] <= wdata_ff[8*b +: 8];
                        end
                    end
                end
            end
            if (gi < calib_pkg::NUM_COEF) begin : g_coef
                assign pif.coef[gi] = cfg_ff[gi];
            end
        end
    endgenerate

    // Thermistor polynomial
    assign therm_ready = !pif.busy;
    assign pif.start   = therm_valid && !pif.busy;
    assign pif.x       = therm_sample;
    assign temp_valid  = pif.done;
    assign temp_out    = pif.result;

    poly_engine u_poly (
        .aclk    (aclk),
        .aresetn (aresetn),
        .p       (pif)
    );

    // Current path
    assign cur_ready     = !cif.busy;
    assign cif.start     = cur_valid && !cif.busy;
    assign cif.raw       = cur_sample;
    assign cif.mult      = cfg_ff[calib_pkg::IDX_CUR_MULT[3:0]];
    assign cif.div       = cfg_ff[calib_pkg::IDX_CUR_DIV[3:0]];
    assign cif.gain      = cfg_ff[calib_pkg::IDX_CUR_GAIN[3:0]];
    assign cif.limit     = cfg_ff[calib_pkg::IDX_CUR_LIM[3:0]];
    assign current_valid = cif.done;
    assign current_out   = cif.result;

    scale_path u_cur (
        .aclk    (aclk),
        .aresetn (aresetn),
        .s       (cif)
    );

    // Voltage path
    assign volt_ready    = !vif.busy;
    assign vif.start     = volt_valid && !vif.busy;
    assign vif.raw       = volt_sample;
    assign vif.mult      = cfg_ff[calib_pkg::IDX_VOLT_MULT[3:0]];
    assign vif.div       = cfg_ff[calib_pkg::IDX_VOLT_DIV[3:0]];
    assign vif.gain      = cfg_ff[calib_pkg::IDX_VOLT_GAIN[3:0]];
    assign vif.limit     = cfg_ff[calib_pkg::IDX_VOLT_LIM[3:0]];
    assign voltage_valid = vif.done;
    assign voltage_out   = vif.result;

    scale_path u_volt (
        .aclk    (aclk),
        .aresetn (aresetn),
        .s       (vif)
    );

    // Deadband classification; negative current is charging
    wire signed [31:0] cur_res = cif.result;
    wire        [31:0] cur_mag = cur_res[31] ? 32'(-cur_res) : cur_res;
    wire        [31:0] hold    = {1'b0, cfg_ff[calib_pkg::IDX_HOLD[3:0]][30:0]};
    wire               outside = cur_mag > hold;
    assign nxt_cstate = !outside ? calib_pkg::ST_REST :
                        cur_res[31] ? calib_pkg::ST_CHARGE : calib_pkg::ST_DISCHARGE;
    assign nxt_acc    = acc_ff + ACC_W'(cur_res);
    assign charge_state = cstate_ff;
    assign charge_acc   = acc_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cstate_ff <= calib_pkg::ST_REST;
            acc_ff    <= '0;
        end else if (cif.done) begin
            cstate_ff <= nxt_cstate;
            acc_ff    <= nxt_acc;
        end
    end

    // Latency, classification and accumulation checks
    a_temp_latency: assert property (@(posedge aclk) disable iff (!aresetn)
        therm_valid && therm_ready |-> ##7 temp_valid)
        else $error("temperature not ready seven cycles after sample");
    a_cur_latency: assert property (@(posedge aclk) disable iff (!aresetn)
        cur_valid && cur_ready |-> ##1 !current_valid ##1 current_valid)
        else $error("current result not after two cycles");
    a_volt_latency: assert property (@(posedge aclk) disable iff (!aresetn)
        volt_valid && volt_ready |-> ##2 voltage_valid)
        else $error("voltage result not after two cycles");
    a_rest_band: assert property (@(posedge aclk) disable iff (!aresetn)
        current_valid && ($signed(current_out) <= $signed(hold))
            && ($signed(current_out) >= -$signed(hold)) |=> charge_state == calib_pkg::ST_REST)
        else $error("inside deadband but not at rest");
    a_sign_state: assert property (@(posedge aclk) disable iff (!aresetn)
        current_valid && $signed(current_out) > $signed(hold)
            |=> charge_state == calib_pkg::ST_DISCHARGE)
        else $error("positive current above hold not discharge");
    a_acc_every: assert property (@(posedge aclk) disable iff (!aresetn)
        current_valid |=> charge_acc == $past(charge_acc) + ACC_W'($signed($past(current_out))))
        else $error("charge not accumulated on a sample");
    // Bus, lockdown, charge sign and thermistor handshake checks
    a_factory_frozen: assert property (@(posedge aclk) disable iff (!aresetn)
        lock_ff && wr_fire && wr_idx_ff == calib_pkg::IDX_CUR_MULT
            |=> $stable(cif.mult) && bresp == calib_pkg::RESP_SLVERR)
        else $error("factory word changed after lockdown");
    a_field_gain_open: assert property (@(posedge aclk) disable iff (!aresetn)
        lock_ff && wr_fire && wr_idx_ff == calib_pkg::IDX_VOLT_GAIN && wstrb_ff == 4'hf
            |=> vif.gain == $past(wdata_ff) && bresp == calib_pkg::RESP_OKAY)
        else $error("field gain refused after lockdown");
    a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped before bready");
    a_ro_refused: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && wr_idx_ff > calib_pkg::IDX_LOCK |=> bresp == calib_pkg::RESP_SLVERR)
        else $error("write to read-only word not refused");
    a_cur_gain_open: assert property (@(posedge aclk) disable iff (!aresetn)
        lock_ff && wr_fire && wr_idx_ff == calib_pkg::IDX_CUR_GAIN && wstrb_ff == 4'hf
            |=> cif.gain == $past(wdata_ff) && bresp == calib_pkg::RESP_OKAY)
        else $error("current gain refused after lockdown");
    a_charge_sign: assert property (@(posedge aclk) disable iff (!aresetn)
        current_valid && $signed(current_out) < -$signed(hold)
            |=> charge_state == calib_pkg::ST_CHARGE)
        else $error("negative current above hold not charging");
    a_therm_busy: assert property (@(posedge aclk) disable iff (!aresetn)
        therm_valid && therm_ready |=> !therm_ready)
        else $error("thermistor engine not busy after sample");

    // Scenario coverage
    c_charging: cover property (@(posedge aclk) disable iff (!aresetn)
        $rose(charge_state == calib_pkg::ST_CHARGE));
    c_discharging: cover property (@(posedge aclk) disable iff (!aresetn)
        $rose(charge_state == calib_pkg::ST_DISCHARGE));
    c_locked_refuse: cover property (@(posedge aclk) disable iff (!aresetn)
        bvalid && lock_ff && bresp == calib_pkg::RESP_SLVERR);
    c_temperature: cover property (@(posedge aclk) disable iff (!aresetn)
        temp_valid);
    c_voltage: cover property (@(posedge aclk) disable iff (!aresetn)
        voltage_valid);
endmodule

// >>> rtl/poly_engine.sv
// Sequential Horner evaluator for the thermistor polynomial
`timescale 1ns/100ps
module poly_engine (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Calculation port
    poly_if.eng      p
);
    typedef enum logic [1:0] {
        S_IDLE = 2'b01,
        S_RUN  = 2'b10
    } eng_state_t;

    eng_state_t         state_ff;
    eng_state_t         nxt_state;
    logic signed [31:0] acc_ff;
    logic signed [31:0] nxt_acc;
    logic signed [31:0] x_ff;
    logic        [2:0]  k_ff;
    logic        [2:0]  nxt_k;
    logic               done_ff;
    logic signed [63:0] prod;
    logic signed [31:0] step;

    // Fixed-point product, then next lower coefficient
    assign prod     = 64'(acc_ff) * 64'(x_ff);
    assign step     = prod[calib_pkg::FRAC_BITS +: 32] + p.coef[k_ff - 3'h1];
    assign p.busy   = (state_ff == S_RUN);
    assign p.done   = done_ff;
    assign p.result = acc_ff;

    always_comb begin
        nxt_state = state_ff;
        nxt_acc   = acc_ff;
        nxt_k     = k_ff;
        unique case (state_ff)
            S_IDLE: begin
                if (p.start) begin
                    nxt_state = S_RUN;
                    nxt_acc   = p.coef[calib_pkg::POLY_ORDER];
                    nxt_k     = 3'(calib_pkg::POLY_ORDER);
                end
            end
            S_RUN: begin
                nxt_acc = step;
                nxt_k   = k_ff - 3'h1;
                if (k_ff == 3'h1) begin
                    nxt_state = S_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= S_IDLE;
            acc_ff   <= 32'h0;
            x_ff     <= 32'h0;
            k_ff     <= 3'h0;
            done_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            acc_ff   <= nxt_acc;
            k_ff     <= nxt_k;
            done_ff  <= (state_ff == S_RUN) && (k_ff == 3'h1);
            if (p.start && state_ff == S_IDLE) begin
                x_ff <= p.x;
            end
        end
    end
endmodule

// >>> rtl/scale_path.sv
// Multiplier/divider scaling followed by the clamped field gain
`timescale 1ns/100ps
module scale_path (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Calculation port
    scale_if.eng     s
);
    logic               s1_ff;
    logic               done_ff;
    logic signed [63:0] scaled_ff;
    logic signed [31:0] gain_ff;
    logic signed [31:0] res_ff;
    logic signed [31:0] lim;
    logic signed [63:0] prod;
    logic signed [63:0] nxt_scaled;
    logic signed [31:0] nxt_gain;
    logic signed [63:0] adj;

    // Limit is a magnitude; top bit ignored
    assign lim        = {1'b0, s.limit[30:0]};
    assign prod       = 64'(s.raw) * 64'(s.mult);
    assign nxt_scaled = (s.div == 32'sh0) ? 64'sh0 : prod / 64'(s.div);
    assign nxt_gain   = (s.gain > lim) ? lim : (s.gain < -lim) ? -lim : s.gain;
    // Gain applied to the already scaled value
    assign adj        = (scaled_ff * 64'(gain_ff)) / 64'(calib_pkg::GAIN_DEN);
    assign s.busy     = s1_ff;
    assign s.done     = done_ff;
    assign s.result   = res_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_ff     <= 1'b0;
            done_ff   <= 1'b0;
            scaled_ff <= 64'sh0;
            gain_ff   <= 32'sh0;
            res_ff    <= 32'sh0;
        end else begin
            s1_ff   <= s.start;
            done_ff <= s1_ff;
            if (s.start) begin
                scaled_ff <= nxt_scaled;
                gain_ff   <= nxt_gain;
            end
            if (s1_ff) begin
                res_ff <= 32'(scaled_ff + adj);
            end
        end
    end

    a_gain_clamp: assert property (@(posedge aclk) disable iff (!aresetn)
        s1_ff |-> (gain_ff <= lim && gain_ff >= -lim))
        else $error("applied gain exceeds limit");
endmodule

// >>> shared/calib_if.sv
// Carriers between the calibration top and its arithmetic engines
`timescale 1ns/100ps
interface poly_if;
    logic               start;
    logic               busy;
    logic               done;
    logic signed [31:0] x;
    logic signed [31:0] coef [calib_pkg::NUM_COEF];
    logic signed [31:0] result;
    modport ctrl (output start, x, coef, input busy, done, result);
    modport eng  (input start, x, coef, output busy, done, result);
endinterface

interface scale_if;
    logic               start;
    logic               busy;
    logic               done;
    logic signed [31:0] raw;
    logic signed [31:0] mult;
    logic signed [31:0] div;
    logic signed [31:0] gain;
    logic        [31:0] limit;
    logic signed [31:0] result;
    modport ctrl (output start, raw, mult, div, gain, limit, input busy, done, result);
    modport eng  (input start, raw, mult, div, gain, limit, output busy, done, result);
endinterface

// >>> shared/calib_pkg.sv
// Constants, register map and types for the measurement calibration block
package calib_pkg;
    localparam int                 DATA_W      = 32;
    localparam int                 AXI_AW      = 8;
    localparam int                 IDX_W       = 6;
    localparam int                 FRAC_BITS   = 16;
    localparam int                 POLY_ORDER  = 6;
    localparam int                 NUM_COEF    = POLY_ORDER + 1;
    localparam int                 NUM_CFG     = 16;
    localparam logic signed [31:0] GAIN_DEN    = 32'sh0001_86a0;
    // Word indices; byte address is four times the index
    localparam logic [5:0] IDX_CUR_MULT  = 6'h07;
    localparam logic [5:0] IDX_CUR_DIV   = 6'h08;
    localparam logic [5:0] IDX_VOLT_MULT = 6'h09;
    localparam logic [5:0] IDX_VOLT_DIV  = 6'h0a;
    localparam logic [5:0] IDX_CUR_GAIN  = 6'h0b;
    localparam logic [5:0] IDX_CUR_LIM   = 6'h0c;
    localparam logic [5:0] IDX_VOLT_GAIN = 6'h0d;
    localparam logic [5:0] IDX_VOLT_LIM  = 6'h0e;
    localparam logic [5:0] IDX_HOLD      = 6'h0f;
    localparam logic [5:0] IDX_LOCK      = 6'h10;
    localparam logic [5:0] IDX_TEMP      = 6'h11;
    localparam logic [5:0] IDX_CUR       = 6'h12;
    localparam logic [5:0] IDX_VOLT      = 6'h13;
    localparam logic [5:0] IDX_STATE     = 6'h14;
    localparam logic [5:0] IDX_ACC_LO    = 6'h15;
    localparam logic [5:0] IDX_ACC_HI    = 6'h16;
    // Config entries that freeze once lockdown is set
    localparam logic [15:0] FACTORY_MASK = 16'hd7ff;
    localparam logic [31:0] CFG_RST [NUM_CFG] = '{
        32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
        32'h1, 32'h1, 32'h1, 32'h586,
        32'h0, 32'h2710, 32'h0, 32'h2710, 32'h4b};
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        ST_REST      = 3'h1,
        ST_CHARGE    = 3'h2,
        ST_DISCHARGE = 3'h4
    } charge_state_t;
endpackage

// >>> testbench/afe_model.sv
// Converter stand-in offering one sample per go pulse
`timescale 1ns/100ps
module afe_model (
    // Clock and command
    input  wire logic        aclk,
    input  wire logic        go,
    input  wire logic [31:0] val,
    // Sample handshake
    input  wire logic        ready,
    output logic             valid,
    output logic [31:0]      sample
);
    initial begin
        valid = 1'b0;
        sample = 32'h0;
    end
    // Released bus shows the inverse of the last sample
    always @(posedge aclk) begin
        if (go) begin
            valid <= 1'b1;
            sample <= val;
        end else if (valid && ready) begin
            valid <= 1'b0;
            sample <= ~sample;
        end
    end
endmodule

// >>> testbench/tb_top.sv
// Self-checking bench for the calibration block
`timescale 1ns/100ps
module tb_top;
    logic                     aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0]               awaddr, araddr;
    logic [31:0]              wdata, val;
    logic [2:0]               go;
    logic [63:0]              acc_e;
    int                       errors, num_checks;
    wire logic                tv, tr, cv, cr, vv, vr, awready, wready, bvalid, arready, rvalid;
    wire logic [2:0]          res_v;
    wire logic [31:0]         ts, cs, vs, rdata, temp_out, current_out, voltage_out;
    wire logic [1:0]          bresp, rresp;
    wire logic [63:0]         charge_acc;
    wire calib_pkg::charge_state_t charge_state;
    int                       cg[6] = '{1000, 20000, -20000, 0, 0, 0};
    int                       craw[6] = '{1000, 1000, 1000, 1000, 50, -1000};
    int                       cexp[6] = '{1515, 1650, 1350, 1500, 75, -1500};
    logic [2:0]               cst[6] = '{3'h4, 3'h4, 3'h4, 3'h4, 3'h1, 3'h2};
    int                       vg[3] = '{-1000, 50000, -50000};
    int                       vexp[3] = '{99, 110, 90};
    measurement_calibration uut (
        .aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .therm_valid(tv), .therm_ready(tr), .therm_sample(ts), .cur_valid(cv), .cur_ready(cr), .cur_sample(cs),
        .volt_valid(vv), .volt_ready(vr), .volt_sample(vs), .temp_valid(res_v[0]), .temp_out,
        .current_valid(res_v[1]), .current_out, .voltage_valid(res_v[2]), .voltage_out, .charge_state, .charge_acc
    );
    afe_model m_t (.aclk, .go(go[0]), .val, .ready(tr), .valid(tv), .sample(ts));
    afe_model m_c (.aclk, .go(go[1]), .val, .ready(cr), .valid(cv), .sample(cs));
    afe_model m_v (.aclk, .go(go[2]), .val, .ready(vr), .valid(vv), .sample(vs));
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task automatic chk(input string nm, input logic [63:0] s, e);
        num_checks++;
        if (s !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic conclude();
        if (errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // One AXI4-Lite write or read, handshakes judged on the sampled levels
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, ex, input logic [1:0] er);
        logic [3:0]  hs;
        logic [31:0] rv;
        logic [1:0]  rr;
        @(posedge aclk);
        {awaddr, araddr, wdata} <= {a, a, d};
        {awvalid, wvalid, bready, arvalid, rready} <= {w, w, w, !w, !w};
        repeat (40) begin
            @(negedge aclk);
            hs = {awready, wready, arready, w ? bvalid : rvalid};
            rv = rdata;
            rr = w ? bresp : rresp;
            @(posedge aclk);
            if (hs[3]) awvalid <= 1'b0;
            if (hs[2]) wvalid <= 1'b0;
            if (hs[1]) arvalid <= 1'b0;
            if (hs[0]) break;
        end
        {bready, rready} <= 2'h0;
        chk("resp", rr, er);
        if (!w) chk("rdata", rv, ex);
    endtask
    // Offer one sample, then check the result pulse and value
    task automatic smp(input int k, input logic [31:0] v, ex);
        @(posedge aclk);
        go[k] <= 1'b1;
        val <= v;
        @(posedge aclk);
        go <= 3'h0;
        repeat (30) begin
            @(negedge aclk);
            if (res_v[k]) break;
        end
        chk("valid", res_v[k], 1'b1);
        chk("out", k == 0 ? temp_out : k == 1 ? current_out : voltage_out, ex);
        @(negedge aclk);
    endtask
    task automatic cur(input logic [31:0] v, ex, input logic [2:0] st);
        smp(1, v, ex);
        acc_e = acc_e + {{32{ex[31]}}, ex};
        chk("state", charge_state, st);
        chk("charge", charge_acc, acc_e);
    endtask
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, aresetn} = 6'h0;
        {awaddr, araddr, wdata, val, go} = '0;
        acc_e = 64'h0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        acc(0, 8'h28, 0, 32'h586, 0);
        acc(0, 8'h24, 0, 32'h1, 0);
        acc(1, 8'h00, 32'h10000, 0, 0);
        acc(1, 8'h04, 32'h20000, 0, 0);
        acc(1, 8'h18, 32'h10000, 0, 0);
        smp(0, 32'h20000, 32'h450000);
        acc(1, 8'h1c, 3, 0, 0);
        acc(1, 8'h20, 2, 0, 0);
        for (int i = 0; i < 6; i++) begin
            acc(1, 8'h2c, cg[i], 0, 0);
            cur(craw[i], cexp[i], cst[i]);
        end
        acc(0, 8'h48, 0, -1500, 0);
        for (int i = 0; i < 3; i++) begin
            acc(1, 8'h34, vg[i], 0, 0);
            smp(2, 32'h22858, vexp[i]);
        end
        acc(1, 8'h40, 1, 0, 0);
        acc(1, 8'h1c, 5, 0, 2);
        acc(0, 8'h1c, 0, 3, 0);
        acc(1, 8'h2c, 0, 0, 0);
        acc(1, 8'h34, 32'h3e8, 0, 0);
        acc(0, 8'h34, 0, 32'h3e8, 0);
        acc(1, 8'h44, 1, 0, 2);
        acc(0, 8'hfc, 0, 0, 2);
        conclude();
    end
    initial begin
        #400000;
        errors++;
        conclude();
    end
endmodule
